// File: core/acc_pkg.sv
package acc_pkg;
  // ==========================================================
  // register map, word index on the plain register port
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam logic [1:0] REG_MASK = 2'h2;
  // ==========================================================
  // bit positions of comparator_status_control
  localparam int CTL_ON = 7;
  localparam int CTL_REF = 6;
  localparam int CTL_FLAG = 5;
  localparam int CTL_IE = 4;
  localparam int CTL_LVL = 3;
  localparam int CTL_PIN = 2;
  // bit positions shared by event status and event mask
  localparam int EVT_CMP = 0;
  localparam int EVT_RISE = 1;
  localparam int EVT_FALL = 2;
  // ==========================================================
  // values after reset, synchroniser stage default and limit
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] EVT_RST = 3'h0;
  localparam int SYNC_STAGES_DEF = 2;
  localparam int SYNC_STAGES_MAX = 8;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MODE_FALL_A = 2'h0,
    MODE_RISE = 2'h1,
    MODE_FALL_B = 2'h2,
    MODE_BOTH = 2'h3
  } acc_mode_t;
  typedef enum logic [2:0] {
    ST_OFF = 3'h1,
    ST_WARM = 3'h2,
    ST_RUN = 3'h4
  } acc_state_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } acc_bus_req_t;
  typedef struct packed {
    logic on;
    logic ref_sel;
    logic ie;
    logic pin_en;
    acc_mode_t mode;
  } acc_cfg_t;
  typedef struct packed {
    logic rise;
    logic fall;
  } acc_edge_t;
endpackage

// File: core/acc_sync.sv
`timescale 1ns/1ps
module acc_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);
  import acc_pkg::*;

  // ==========================================================
  // elaboration check
  generate
    if (STAGES < 2 || STAGES > SYNC_STAGES_MAX) begin : g_bad
      $error("acc_sync: STAGES out of range");
    end
  endgenerate

  logic [STAGES-1:0] chain_ff;

  // first stage feeds only the next stage
  always_ff @(posedge clk) begin
    if (reset) begin
      chain_ff <= '0;
    end else begin
      chain_ff <= {chain_ff[STAGES-2:0], async_in};
    end
  end

  assign sync_out = chain_ff[STAGES-1];
endmodule

// File: core/acc_edge.sv
`timescale 1ns/1ps
module acc_edge (
  input wire logic clk,
  input wire logic reset,
  input wire logic level,
  input wire logic arm,
  output acc_pkg::acc_edge_t edges
);
  import acc_pkg::*;

  logic prev_ff;

  // previous level tracks even while disarmed, so the
  // first armed cycle compares against a valid sample
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= level;
    end
  end

  // one driver for the whole struct
  assign edges = '{rise: arm & level & ~prev_ff,
    fall: arm & ~level & prev_ff};
endmodule

// File: core/acc_comparator_ctrl.sv
`timescale 1ns/1ps
module acc_comparator_ctrl #(
  parameter int SYNC_STAGES = acc_pkg::SYNC_STAGES_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire acc_pkg::acc_bus_req_t bus,
  output logic [acc_pkg::DATA_W-1:0] rdata,
  input wire logic comp_raw,
  input wire logic stop_mode,
  output logic analog_on,
  output logic ref_select,
  output logic out_pin,
  output logic out_pin_oe_n,
  output logic irq
);
  import acc_pkg::*;

  // ==========================================================
  // elaboration check
  generate
    if (SYNC_STAGES < 2 || SYNC_STAGES > SYNC_STAGES_MAX) begin : g_bad
      $error("acc_comparator_ctrl: SYNC_STAGES out of range");
    end
  endgenerate

  // sync flush plus one cycle to load the edge reference
  localparam logic [3:0] WARM_LAST = 4'(SYNC_STAGES);

  // ==========================================================
  // state
  acc_cfg_t cfg_ff, nxt_cfg;
  acc_state_t state_ff, nxt_state;
  logic [3:0] warm_ff, nxt_warm;
  logic flag_ff, nxt_flag;
  logic rise_seen_ff, nxt_rise_seen;
  logic fall_seen_ff, nxt_fall_seen;
  logic mask_rise_ff, nxt_mask_rise;
  logic mask_fall_ff, nxt_mask_fall;
  logic level_ff, nxt_level;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic analog_on_ff;
  logic ref_select_ff;
  logic out_pin_ff;
  logic out_pin_oe_n_ff;
  logic irq_ff, nxt_irq;

  // ==========================================================
  // comparator input path
  logic comp_sync;
  acc_edge_t edges;
  logic run;

  // raw output is high when + exceeds -, asynchronous to clk
  acc_sync #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in(comp_raw),
    .sync_out(comp_sync)
  );

  // edges only count once the synchroniser has settled
  acc_edge u_edge (
    .clk(clk),
    .reset(reset),
    .level(comp_sync),
    .arm(run),
    .edges(edges)
  );

  // ==========================================================
  // register port decode
  logic wr_ctrl, wr_stat, wr_mask;
  logic rd_ctrl, rd_stat, rd_mask;
  logic clr_flag, clr_rise, clr_fall;
  logic active_req, ref_change;
  logic hit;

  assign wr_ctrl = bus.wr && bus.addr == REG_CTRL;
  assign wr_stat = bus.wr && bus.addr == REG_STAT;
  assign wr_mask = bus.wr && bus.addr == REG_MASK;
  assign rd_ctrl = bus.rd && bus.addr == REG_CTRL;
  assign rd_stat = bus.rd && bus.addr == REG_STAT;
  assign rd_mask = bus.rd && bus.addr == REG_MASK;

  // write-one-to-clear, reachable from either view of the flag
  assign clr_flag = (wr_ctrl & bus.wdata[CTL_FLAG])
    | (wr_stat & bus.wdata[EVT_CMP]);
  assign clr_rise = wr_stat & bus.wdata[EVT_RISE];
  assign clr_fall = wr_stat & bus.wdata[EVT_FALL];

  // stop overrides the enable without touching the register
  assign active_req = cfg_ff.on & ~stop_mode;
  // a new reference source glitches the output: settle again
  assign ref_change = wr_ctrl
    && bus.wdata[CTL_REF] != cfg_ff.ref_sel;
  assign run = state_ff == ST_RUN;

  // ==========================================================
  // event selection by mode
  function automatic logic mode_hit(
    input acc_mode_t mode,
    input acc_edge_t e
  );
    logic h;
    h = 1'b0;
    case (mode)
      MODE_FALL_A: h = e.fall;
      MODE_RISE: h = e.rise;
      MODE_FALL_B: h = e.fall;
      MODE_BOTH: h = e.rise | e.fall;
      default: h = 1'b0;
    endcase
    return h;
  endfunction

  assign hit = mode_hit(cfg_ff.mode, edges);

  // ==========================================================
  // control fields, bit 3 is read only
  always_comb begin
    nxt_cfg = cfg_ff;
    if (wr_ctrl) begin
      nxt_cfg.on = bus.wdata[CTL_ON];
      nxt_cfg.ref_sel = bus.wdata[CTL_REF];
      nxt_cfg.ie = bus.wdata[CTL_IE];
      nxt_cfg.pin_en = bus.wdata[CTL_PIN];
      nxt_cfg.mode = acc_mode_t'(bus.wdata[1:0]);
    end else if (wr_mask) begin
      nxt_cfg.ie = bus.wdata[EVT_CMP];
    end
  end

  // ==========================================================
  // enable sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_warm = warm_ff;
    case (state_ff)
      ST_OFF: begin
        nxt_warm = 4'h0;
        if (active_req) begin
          nxt_state = ST_WARM;
        end
      end
      ST_WARM: begin
        nxt_warm = warm_ff + 4'h1;
        if (!active_req) begin
          nxt_state = ST_OFF;
        end else if (ref_change) begin
          nxt_warm = 4'h0;
        end else if (warm_ff == WARM_LAST) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_warm = 4'h0;
        if (!active_req) begin
          nxt_state = ST_OFF;
        end else if (ref_change) begin
          nxt_state = ST_WARM;
        end
      end
      default: begin
        nxt_state = ST_OFF;
        nxt_warm = 4'h0;
      end
    endcase
  end

  // ==========================================================
  // sticky events: a set in the clear cycle wins
  assign nxt_flag = hit | (flag_ff & ~clr_flag);
  assign nxt_rise_seen = edges.rise | (rise_seen_ff & ~clr_rise);
  assign nxt_fall_seen = edges.fall | (fall_seen_ff & ~clr_fall);
  assign nxt_mask_rise = wr_mask ? bus.wdata[EVT_RISE] : mask_rise_ff;
  assign nxt_mask_fall = wr_mask ? bus.wdata[EVT_FALL] : mask_fall_ff;

  // irq from next values so it rises with the flag itself
  assign nxt_irq = (nxt_flag & nxt_cfg.ie)
    | (nxt_rise_seen & nxt_mask_rise)
    | (nxt_fall_seen & nxt_mask_fall);

  // level reads zero unless the comparator runs
  assign nxt_level = (nxt_state == ST_RUN) & comp_sync;

  // ==========================================================
  // read data stand for one cycle, zero otherwise
  always_comb begin
    nxt_rdata = '0;
    if (rd_ctrl) begin
      nxt_rdata = {cfg_ff.on, cfg_ff.ref_sel, flag_ff,
        cfg_ff.ie, level_ff, cfg_ff.pin_en, cfg_ff.mode};
    end else if (rd_stat) begin
      nxt_rdata = {5'h00, fall_seen_ff, rise_seen_ff, flag_ff};
    end else if (rd_mask) begin
      nxt_rdata = {5'h00, mask_fall_ff, mask_rise_ff, cfg_ff.ie};
    end
  end

  // ==========================================================
  // register update
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_ff <= acc_cfg_t'(6'h00);
      state_ff <= ST_OFF;
      warm_ff <= 4'h0;
      flag_ff <= 1'b0;
      rise_seen_ff <= 1'b0;
      fall_seen_ff <= 1'b0;
      mask_rise_ff <= 1'b0;
      mask_fall_ff <= 1'b0;
      level_ff <= 1'b0;
      rdata_ff <= CTRL_RST;
      irq_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      state_ff <= nxt_state;
      warm_ff <= nxt_warm;
      flag_ff <= nxt_flag;
      rise_seen_ff <= nxt_rise_seen;
      fall_seen_ff <= nxt_fall_seen;
      mask_rise_ff <= nxt_mask_rise;
      mask_fall_ff <= nxt_mask_fall;
      level_ff <= nxt_level;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  // analog side controls and the output pin
  always_ff @(posedge clk) begin
    if (reset) begin
      analog_on_ff <= 1'b0;
      ref_select_ff <= 1'b0;
      out_pin_ff <= 1'b0;
      out_pin_oe_n_ff <= 1'b1;
    end else begin
      analog_on_ff <= nxt_cfg.on & ~stop_mode;
      ref_select_ff <= nxt_cfg.ref_sel;
      out_pin_ff <= nxt_cfg.pin_en & nxt_level;
      out_pin_oe_n_ff <= ~nxt_cfg.pin_en;
    end
  end

  assign rdata = rdata_ff;
  assign analog_on = analog_on_ff;
  assign ref_select = ref_select_ff;
  assign out_pin = out_pin_ff;
  assign out_pin_oe_n = out_pin_oe_n_ff;
  assign irq = irq_ff;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  flag_sets_a: assert property (
    hit |=> flag_ff
  ) else $error("flag not set after compare event");

  flag_w1c_a: assert property (
    flag_ff && clr_flag && !hit |=> !flag_ff
  ) else $error("flag not cleared by write one");

  flag_keep_a: assert property (
    flag_ff && !clr_flag |=> flag_ff
  ) else $error("flag lost without a clear");

  clear_race_a: assert property (
    clr_flag && hit |=> flag_ff
  ) else $error("event lost in clear cycle");

  irq_level_a: assert property (
    cfg_ff.ie && flag_ff |-> irq
  ) else $error("irq low while enabled flag set");

  irq_quiet_a: assert property (
    !flag_ff && !rise_seen_ff && !fall_seen_ff |-> !irq
  ) else $error("irq high with no event pending");

  level_off_a: assert property (
    !cfg_ff.on |=> !level_ff
  ) else $error("level readback nonzero while disabled");

  ctrl_read_a: assert property (
    rd_ctrl |=> rdata[CTL_LVL] == $past(level_ff)
      && rdata[CTL_ON] == $past(cfg_ff.on)
  ) else $error("control read data wrong");

  stop_idle_a: assert property (
    stop_mode |=> !analog_on && !run
  ) else $error("comparator active in stop");

  pin_drive_a: assert property (
    !cfg_ff.pin_en |-> out_pin_oe_n && !out_pin
  ) else $error("output pin driven while disabled");

  mode_rise_a: assert property (
    cfg_ff.mode == MODE_RISE && edges.fall && !edges.rise
      && !flag_ff |=> !flag_ff
  ) else $error("falling edge set flag in rising mode");

  warm_time_a: assert property (
    state_ff == ST_OFF ##1 state_ff == ST_WARM |-> !run [*2]
  ) else $error("edge detection armed before settling");

  read_once_a: assert property (
    !bus.rd |=> rdata == '0
  ) else $error("read data held beyond one cycle");

  irq_mask_a: assert property (
    rise_seen_ff && mask_rise_ff || fall_seen_ff && mask_fall_ff |-> irq
  ) else $error("irq low with unmasked event pending");

  ref_settle_a: assert property (
    run && ref_change |=> !run
  ) else $error("edge detection kept through reference change");

  // main scenarios
  cov_rise_c: cover property (
    cfg_ff.mode == MODE_RISE && edges.rise ##1 irq
  );
  cov_both_c: cover property (
    cfg_ff.mode == MODE_BOTH && hit ##[1:50] hit
  );
  cov_race_c: cover property (clr_flag && hit);
  cov_stop_c: cover property (run ##1 stop_mode ##1 !run);
endmodule

// File: sim/acc_analog_model.sv
`timescale 1ns/1ps
// ==========================================================
// analog comparator circuit as seen from the control block
module acc_analog_model #(
  parameter int BANDGAP_MV = 1200
) (
  input wire logic clk,
  input wire logic powered,
  input wire logic use_bandgap,
  input wire logic [15:0] pos_mv,
  input wire logic [15:0] neg_mv,
  output logic comp_raw
);
  logic idle_toggle = 1'b0;
  logic [15:0] plus_mv;
  // non-inverting input mux: pin or internal reference
  assign plus_mv = use_bandgap ? 16'(BANDGAP_MV) : pos_mv;
  // unpowered output is meaningless, so it wanders every cycle
  always @(posedge clk) begin
    idle_toggle <= ~idle_toggle;
  end
  // when powered, high only when non-inverting input is above inverting input
  assign comp_raw = powered ? (plus_mv > neg_mv) : idle_toggle;
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
  import acc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  acc_bus_req_t bus = '0;
  logic [7:0] rdata;
  logic comp_raw;
  logic stop_mode = 1'b0;
  logic analog_on, ref_select, out_pin, out_pin_oe_n, irq;
  logic [15:0] pos_mv = 16'h07D0;
  logic [15:0] neg_mv = 16'h03E8;
  int failures = 0;
  int checked = 0;
  int m;

  // 25 MHz clock
  always #20 clk = ~clk;

  acc_comparator_ctrl dut (
    .clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
    .comp_raw(comp_raw), .stop_mode(stop_mode),
    .analog_on(analog_on), .ref_select(ref_select),
    .out_pin(out_pin), .out_pin_oe_n(out_pin_oe_n), .irq(irq));

  acc_analog_model cmp (
    .clk(clk), .powered(analog_on), .use_bandgap(ref_select),
    .pos_mv(pos_mv), .neg_mv(neg_mv), .comp_raw(comp_raw));

  // ==========================================================
  // access and compare tasks
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rd(logic [1:0] a, logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // pins in order: analog_on, out_pin, out_pin_oe_n, irq
  task automatic pins(logic [3:0] exp);
    #1;
    chk({4'h0, analog_on, out_pin, out_pin_oe_n, irq}, {4'h0, exp});
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog: whole run needs well under a thousand cycles
  initial begin
    idle(5000);
    failures++;
    report_and_stop();
  end

  // ==========================================================
  // test sequence
  initial begin
    idle(5);
    reset <= 1'b0;
    pins(4'b0010);
    rd(REG_CTRL, CTRL_RST);
    rd(REG_STAT, 8'h00);
    rd(REG_MASK, 8'h00);
    rd(2'h3, 8'h00);
    // disabled: level must read zero while the analog side wanders
    wr(REG_CTRL, 8'h04);
    idle(4);
    rd(REG_CTRL, 8'h04);
    pins(4'b0000);
    pos_mv <= 16'h01F4;
    wr(REG_CTRL, 8'h95);
    pins(4'b1000);
    idle(6);
    pos_mv <= 16'h07D0;
    idle(5);
    rd(REG_CTRL, 8'hBD);
    pins(4'b1101);
    wr(REG_CTRL, 8'h95);
    rd(REG_CTRL, 8'hBD);
    wr(REG_CTRL, 8'hB5);
    rd(REG_CTRL, 8'h9D);
    pins(4'b1100);
    // event status and mask drive the same interrupt line
    rd(REG_STAT, 8'h02);
    wr(REG_MASK, 8'h02);
    pins(4'b1101);
    wr(REG_STAT, 8'h07);
    pins(4'b1100);
    rd(REG_STAT, 8'h00);
    wr(REG_MASK, 8'h00);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    rd(REG_CTRL, 8'h8D);
    // every edge code against a fall and then a rise
    for (m = 0; m < 4; m++) begin
      wr(REG_CTRL, 8'hA0 | 8'(m));
      pos_mv <= 16'h01F4;
      idle(5);
      rd(REG_CTRL, ((m == 1) ? 8'h80 : 8'hA0) | 8'(m));
      wr(REG_CTRL, 8'hA0 | 8'(m));
      pos_mv <= 16'h07D0;
      idle(5);
      rd(REG_CTRL, ((m % 2 == 1) ? 8'hA8 : 8'h88) | 8'(m));
    end
    // both edge kinds seen; falling mask alone raises the line
    rd(REG_STAT, 8'h07);
    wr(REG_MASK, 8'h04);
    rd(REG_MASK, 8'h04);
    pins(4'b1011);
    wr(REG_STAT, 8'h06);
    pins(4'b1010);
    wr(REG_MASK, 8'h00);
    // clear lands on the edge that records a rise
    wr(REG_CTRL, 8'hB1);
    pos_mv <= 16'h01F4;
    idle(5);
    pos_mv <= 16'h07D0;
    idle(1);
    wr(REG_CTRL, 8'hB1);
    rd(REG_CTRL, 8'hB9);
    // internal reference: pin above, reference first above then below the minus input
    wr(REG_CTRL, 8'hE0);
    idle(6);
    rd(REG_CTRL, 8'hC8);
    chk({7'h00, ref_select}, 8'h01);
    neg_mv <= 16'h05DC;
    idle(5);
    rd(REG_CTRL, 8'hE0);
    // stop: no compare and no events whatever the settings
    wr(REG_CTRL, 8'hB1);
    neg_mv <= 16'h03E8;
    idle(6);
    stop_mode <= 1'b1;
    pos_mv <= 16'h01F4;
    idle(2);
    pins(4'b0010);
    pos_mv <= 16'h07D0;
    idle(5);
    rd(REG_CTRL, 8'h91);
    stop_mode <= 1'b0;
    report_and_stop();
  end
endmodule
